/* qbs_consts.svh */
// register offsets, bit positions and reset values of the status/mask block
`ifndef QBS_CONSTS_SVH
`define QBS_CONSTS_SVH

`define QBS_ADDR_CORE01_STATUS 8'h1c
`define QBS_ADDR_CORE23_STATUS 8'h1d
`define QBS_ADDR_TOP_MASK 8'h1e
`define QBS_ADDR_CORE01_MASK 8'h1f

// per-core status byte layout, even core low nibble, odd core high nibble
`define QBS_BIT_EVEN_OC 0
`define QBS_BIT_EVEN_RSV 1
`define QBS_BIT_EVEN_LOW 2
`define QBS_BIT_EVEN_EN 3
`define QBS_BIT_ODD_OC 4
`define QBS_BIT_ODD_RSV 5
`define QBS_BIT_ODD_LOW 6
`define QBS_BIT_ODD_EN 7
`define QBS_STATUS_RESET 8'h00

// top mask layout
`define QBS_BIT_LOAD_READY_MASK 0
`define QBS_BIT_REG_RESET_MASK 1
`define QBS_BIT_THERMAL_MASK 2
`define QBS_TOP_MASK_RESET 8'h02
`define QBS_TOP_MASK_WRITABLE 8'hff

// core 0/1 mask layout
`define QBS_BIT_CORE0_OC_MASK 0
`define QBS_BIT_CORE0_GOOD_MASK 2
`define QBS_BIT_CORE1_OC_MASK 4
`define QBS_BIT_CORE1_GOOD_MASK 6
`define QBS_CORE01_MASK_RESET 8'h55
`define QBS_CORE01_MASK_WRITABLE 8'hdd

// latched event vector layout
`define QBS_EV_LOAD_READY 0
`define QBS_EV_REG_RESET 1
`define QBS_EV_THERMAL 2
`define QBS_EV_CORE0_OC 3
`define QBS_EV_CORE0_GOOD 4
`define QBS_EV_CORE1_OC 5
`define QBS_EV_CORE1_GOOD 6
`define QBS_EV_COUNT 7

`define QBS_READ_IDLE 8'h00

`endif

/* qbs_core_status.sv */
// status byte for one pair of converter cores, sampled every cycle
`timescale 1ns/10ps
`include "qbs_consts.svh"
module qbs_core_status
  import qbs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic even_enabled,
  input wire logic even_low,
  input wire logic even_overcurrent,
  input wire logic odd_enabled,
  input wire logic odd_low,
  input wire logic odd_overcurrent,
  output qbs_byte_type status
);
  // assembled raw byte, reserved lanes tied low
  qbs_byte_type next_status;

  assign next_status[`QBS_BIT_EVEN_OC] = even_overcurrent;
  assign next_status[`QBS_BIT_EVEN_RSV] = 1'b0;
  assign next_status[`QBS_BIT_EVEN_LOW] = even_low;
  assign next_status[`QBS_BIT_EVEN_EN] = even_enabled;
  assign next_status[`QBS_BIT_ODD_OC] = odd_overcurrent;
  assign next_status[`QBS_BIT_ODD_RSV] = 1'b0;
  assign next_status[`QBS_BIT_ODD_LOW] = odd_low;
  assign next_status[`QBS_BIT_ODD_EN] = odd_enabled;

  // resample every cycle, no host refresh needed
  always_ff @(posedge clk) begin
    if (!rstn) begin
      status <= `QBS_STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  status_enable_a: assert property (@(posedge clk) disable iff (!rstn)
    ##1 (status[`QBS_BIT_EVEN_EN] == $past(even_enabled) &&
         status[`QBS_BIT_ODD_EN] == $past(odd_enabled)))
    else $error("enable status bit does not follow core");
  status_low_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(odd_low) |=> status[`QBS_BIT_ODD_LOW] &&
      $rose(status[`QBS_BIT_ODD_LOW]))
    else $error("output low bit late or wrong");
  status_oc_a: assert property (@(posedge clk) disable iff (!rstn)
    even_overcurrent [*2] |=> status[`QBS_BIT_EVEN_OC] [*1])
    else $error("current limit bit not shown");
  status_rsv_a: assert property (@(posedge clk) disable iff (!rstn)
    !status[`QBS_BIT_EVEN_RSV] && !status[`QBS_BIT_ODD_RSV])
    else $error("reserved status bit set");
endmodule

/* qbs_event_latch.sv */
// sticky event flags, cleared by a one written to the bit position
`timescale 1ns/10ps
`include "qbs_consts.svh"
module qbs_event_latch
  import qbs_pkg::*;
#(
  parameter int WIDTH = `QBS_EV_COUNT
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clear,
  output logic [WIDTH-1:0] flags
);
  // width must hold at least one flag
  if (WIDTH < 1) begin : g_bad_width
    $error("qbs_event_latch needs WIDTH of at least 1");
  end

  // set outranks clear so an event in the clear cycle survives
  wire [WIDTH-1:0] next_flags = set | (flags & ~clear);

  // flags hold until cleared
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  latch_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    (flags[0] && !clear[0] && !set[0]) |=> flags[0])
    else $error("flag dropped without a clear");
  latch_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    (clear[0] && !set[0]) |=> !flags[0])
    else $error("flag not cleared by written one");
  latch_setwin_a: assert property (@(posedge clk) disable iff (!rstn)
    set[WIDTH-1] |=> flags[WIDTH-1])
    else $error("event lost against a clear");
endmodule

/* qbs_host_model.sv */
// host side of the byte register port, one strobe per access
`timescale 1ns/10ps
module qbs_host_model
  import qbs_pkg::*;
(
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output qbs_byte_type reg_wdata,
  input wire qbs_byte_type reg_rdata
);
  // idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // write: held over one sampling edge, then strobe dropped and data inverted, address kept
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    // stale data must not look valid
    reg_wdata = ~d;
  endtask
  // read: data is registered at the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule

/* qbs_pkg.sv */
// shared types of the status/mask block
package qbs_pkg;
  typedef logic [7:0] qbs_byte_type;
  // which register a read selects
  typedef enum logic [2:0] {
    QBS_SEL_NONE = 3'b000,
    QBS_SEL_CORE01_STATUS = 3'b001,
    QBS_SEL_CORE23_STATUS = 3'b010,
    QBS_SEL_TOP_MASK = 3'b011,
    QBS_SEL_CORE01_MASK = 3'b100
  } qbs_sel_type;
endpackage

/* qbs_status_irq.sv */
// status and interrupt mask registers of the four-core regulator
`timescale 1ns/10ps
`include "qbs_consts.svh"
//
// Function
// - core 0/1 enable shown at bits 3, 7
// - core 2/3 enable shown at bits 3, 7
// - output-low raw at bit 2 or 6
// - current-limit raw at bit 0 or 4
// - status read-only, reserved zero, reset zero
// - thermal mask bit 2, resets 0
// - register-reset mask bit 1, resets 1
// - load-ready mask bit 0, resets 0
// - top mask bits 7:3 spare, reset 0
// - power-good masks bits 6, 2 reset 1
// - current-limit masks bits 4, 0 reset 1
// - core mask bits 5,1 zero; 7,3 spare
// - flags stay until host writes one
// - power-good flag on reaching threshold
module qbs_status_irq
  import qbs_pkg::*;
#(
  parameter int NUM_CORES = 4
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [NUM_CORES-1:0] core_enabled_flag,
  input wire logic [NUM_CORES-1:0] core_output_low_raw,
  input wire logic [NUM_CORES-1:0] core_overcurrent_raw,
  input wire logic thermal_warning_raw,
  input wire logic reg_reset_pulse,
  input wire logic load_ready_pulse,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire qbs_byte_type reg_wdata,
  output qbs_byte_type reg_rdata,
  input wire logic [`QBS_EV_COUNT-1:0] event_clear,
  output logic [`QBS_EV_COUNT-1:0] event_flags,
  output logic irq
);
  // two status bytes cover exactly four cores
  if (NUM_CORES != 4) begin : g_bad_cores
    $error("qbs_status_irq serves exactly four cores");
  end

  localparam int NUM_PAIRS = NUM_CORES / 2;

  // status bytes, one per core pair
  qbs_byte_type pair_status [NUM_PAIRS];
  // mask registers
  qbs_byte_type top_event_mask;
  qbs_byte_type core01_event_mask;
  // previous samples for edge detection
  logic thermal_prev;
  logic [1:0] low_prev;
  // event set vector into the latch
  logic [`QBS_EV_COUNT-1:0] event_set;
  // read path
  qbs_sel_type read_sel;
  qbs_byte_type next_rdata;
  logic next_irq;

  // one status byte per pair; pair 1 is the core 2/3 register
  // the odd core of a pair fills the high nibble
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    qbs_core_status u_status (
      .clk(clk),
      .rstn(rstn),
      .even_enabled(core_enabled_flag[2*p]),
      .even_low(core_output_low_raw[2*p]),
      .even_overcurrent(core_overcurrent_raw[2*p]),
      .odd_enabled(core_enabled_flag[2*p+1]),
      .odd_low(core_output_low_raw[2*p+1]),
      .odd_overcurrent(core_overcurrent_raw[2*p+1]),
      .status(pair_status[p])
    );
  end

  // named mask fields
  wire load_ready_irq_mask = top_event_mask[`QBS_BIT_LOAD_READY_MASK];
  wire reg_reset_irq_mask = top_event_mask[`QBS_BIT_REG_RESET_MASK];
  wire thermal_warning_irq_mask = top_event_mask[`QBS_BIT_THERMAL_MASK];
  wire core0_overcurrent_irq_mask =
    core01_event_mask[`QBS_BIT_CORE0_OC_MASK];
  wire core0_good_irq_mask = core01_event_mask[`QBS_BIT_CORE0_GOOD_MASK];
  wire core1_overcurrent_irq_mask =
    core01_event_mask[`QBS_BIT_CORE1_OC_MASK];
  wire core1_good_irq_mask = core01_event_mask[`QBS_BIT_CORE1_GOOD_MASK];

  // event detection; masks never touch the raw bits or the flags
  wire thermal_warning_event = thermal_warning_raw && !thermal_prev;
  // output leaving the low state means the threshold was reached
  wire core0_good_event = low_prev[0] && !core_output_low_raw[0];
  wire core1_good_event = low_prev[1] && !core_output_low_raw[1];
  // current limit keeps setting its flag while active
  wire core0_overcurrent_event = core_overcurrent_raw[0];
  wire core1_overcurrent_event = core_overcurrent_raw[1];
  // cores 2 and 3 raise no events here; their flags live elsewhere

  assign event_set[`QBS_EV_LOAD_READY] = load_ready_pulse;
  assign event_set[`QBS_EV_REG_RESET] = reg_reset_pulse;
  assign event_set[`QBS_EV_THERMAL] = thermal_warning_event;
  assign event_set[`QBS_EV_CORE0_OC] = core0_overcurrent_event;
  assign event_set[`QBS_EV_CORE0_GOOD] = core0_good_event;
  assign event_set[`QBS_EV_CORE1_OC] = core1_overcurrent_event;
  assign event_set[`QBS_EV_CORE1_GOOD] = core1_good_event;

  // sticky flags, one-written clears
  qbs_event_latch #(
    .WIDTH(`QBS_EV_COUNT)
  ) u_latch (
    .clk(clk),
    .rstn(rstn),
    .set(event_set),
    .clear(event_clear),
    .flags(event_flags)
  );

  // mask vector in the layout of the flag vector
  // the order must match the flags, or a mask hides the wrong one
  wire [`QBS_EV_COUNT-1:0] event_mask = {
    core1_good_irq_mask, core1_overcurrent_irq_mask,
    core0_good_irq_mask, core0_overcurrent_irq_mask,
    thermal_warning_irq_mask, reg_reset_irq_mask, load_ready_irq_mask};

  // a zero mask bit lets its flag through
  assign next_irq = |(event_flags & ~event_mask);

  // write decode
  // status addresses are not decoded, so writes there are dropped
  wire wr_top_mask = reg_wr && (reg_addr == `QBS_ADDR_TOP_MASK);
  wire wr_core01_mask = reg_wr && (reg_addr == `QBS_ADDR_CORE01_MASK);
  // read-only lanes of the core mask keep their zero
  wire [7:0] core01_mask_wval = reg_wdata & `QBS_CORE01_MASK_WRITABLE;

  // edge detector history
  always_ff @(posedge clk) begin
    if (!rstn) begin
      // idle levels, so no false edge follows reset
      thermal_prev <= 1'b0;
      low_prev <= 2'b00;
    end else begin
      thermal_prev <= thermal_warning_raw;
      low_prev <= core_output_low_raw[1:0];
    end
  end

  // top mask, every bit writable including spare high bits
  always_ff @(posedge clk) begin
    if (!rstn) begin
      top_event_mask <= `QBS_TOP_MASK_RESET;
    end else if (wr_top_mask) begin
      // spare bits keep whatever the host wrote
      top_event_mask <= reg_wdata & `QBS_TOP_MASK_WRITABLE;
    end
  end

  // core 0/1 mask; status writes are simply not decoded
  always_ff @(posedge clk) begin
    if (!rstn) begin
      core01_event_mask <= `QBS_CORE01_MASK_RESET;
    end else if (wr_core01_mask) begin
      // lanes 5 and 1 stay zero whatever is written
      core01_event_mask <= core01_mask_wval;
    end
  end

  // read select
  // priority order does not matter, the addresses are distinct
  assign read_sel =
    (reg_addr == `QBS_ADDR_CORE01_STATUS) ? QBS_SEL_CORE01_STATUS :
    (reg_addr == `QBS_ADDR_CORE23_STATUS) ? QBS_SEL_CORE23_STATUS :
    (reg_addr == `QBS_ADDR_TOP_MASK) ? QBS_SEL_TOP_MASK :
    (reg_addr == `QBS_ADDR_CORE01_MASK) ? QBS_SEL_CORE01_MASK :
    QBS_SEL_NONE;

  // read mux; unmapped addresses return zero
  always_comb begin
    case (read_sel)
      QBS_SEL_CORE01_STATUS: begin
        // cores 0 and 1, raw conditions
        next_rdata = pair_status[0];
      end
      QBS_SEL_CORE23_STATUS: begin
        // cores 2 and 3, raw conditions
        next_rdata = pair_status[1];
      end
      QBS_SEL_TOP_MASK: begin
        // all eight bits as written
        next_rdata = top_event_mask;
      end
      QBS_SEL_CORE01_MASK: begin
        // read-only lanes already hold zero
        next_rdata = core01_event_mask;
      end
      default: begin
        // unmapped address
        next_rdata = `QBS_READ_IDLE;
      end
    endcase
  end

  // read data stands until the next read
  // a write in the same cycle is not seen; the old value is read
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= `QBS_READ_IDLE;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // registered interrupt level, one cycle behind the flags
  // registered so the pin cannot glitch while flags settle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  irq_raise_a: assert property (@(posedge clk) disable iff (!rstn)
    |(event_flags & ~event_mask) |=> irq)
    else $error("interrupt missing for unmasked flag");
  irq_drop_a: assert property (@(posedge clk) disable iff (!rstn)
    (event_flags & ~event_mask) == '0 |=> !irq)
    else $error("interrupt with no unmasked flag");
  mask_reset_a: assert property (@(posedge clk)
    !rstn |=> (top_event_mask == `QBS_TOP_MASK_RESET &&
               core01_event_mask == `QBS_CORE01_MASK_RESET))
    else $error("mask reset value wrong");
  mask_ro_a: assert property (@(posedge clk) disable iff (!rstn)
    (core01_event_mask & ~`QBS_CORE01_MASK_WRITABLE) == 8'h00)
    else $error("read-only mask bit set");
  top_write_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_top_mask |=> top_event_mask == $past(reg_wdata))
    else $error("top mask write lost");
  good_event_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(core_output_low_raw[0]) |=> event_flags[`QBS_EV_CORE0_GOOD])
    else $error("power-good flag not set");
  mask_keeps_flag_a: assert property (@(posedge clk)
    disable iff (!rstn)
    (core0_good_event && core0_good_irq_mask) |=>
      event_flags[`QBS_EV_CORE0_GOOD])
    else $error("mask altered the flag");

  // read path: a register reaches the data port at the strobe edge
  read_top_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_rd && reg_addr == `QBS_ADDR_TOP_MASK) |=>
      reg_rdata == $past(top_event_mask))
    else $error("top mask read wrong");
  read_pair_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_rd && reg_addr == `QBS_ADDR_CORE23_STATUS) |=>
      reg_rdata == $past(pair_status[1]))
    else $error("core 2/3 status read wrong");
  read_mask_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_rd && reg_addr == `QBS_ADDR_CORE01_MASK) |=>
      (reg_rdata & ~`QBS_CORE01_MASK_WRITABLE) == 8'h00)
    else $error("read-only mask lane read as one");
  read_none_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_rd && read_sel == QBS_SEL_NONE) |=> reg_rdata == `QBS_READ_IDLE)
    else $error("unmapped address read not zero");
  // data port holds between strobes, so a slow host may read it late
  read_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a strobe");

  // status addresses take no writes, so no mask may move
  status_wr_a: assert property (@(posedge clk) disable iff (!rstn)
    (reg_wr && (reg_addr == `QBS_ADDR_CORE01_STATUS ||
                reg_addr == `QBS_ADDR_CORE23_STATUS)) |=>
      $stable(top_event_mask) && $stable(core01_event_mask))
    else $error("status write reached a mask");
  // flag sources
  thermal_flag_a: assert property (@(posedge clk)
    disable iff (!rstn)
    $rose(thermal_warning_raw) |=> event_flags[`QBS_EV_THERMAL])
    else $error("thermal warning flag not set");
  oc_flag_a: assert property (@(posedge clk) disable iff (!rstn)
    core_overcurrent_raw[1] |=> event_flags[`QBS_EV_CORE1_OC])
    else $error("current limit flag not set");

  // an unmasked flag reaches the pin, checked for five of the seven mask lanes (not core 0 power-good or core 1 current limit)
  load_pass_a: assert property (@(posedge clk) disable iff (!rstn)
    (event_flags[`QBS_EV_LOAD_READY] && !load_ready_irq_mask) |=> irq)
    else $error("load ready flag not reaching interrupt");
  reset_pass_a: assert property (@(posedge clk)
    disable iff (!rstn)
    (event_flags[`QBS_EV_REG_RESET] && !reg_reset_irq_mask) |=> irq)
    else $error("register reset flag not reaching interrupt");
  thermal_pass_a: assert property (@(posedge clk)
    disable iff (!rstn)
    (event_flags[`QBS_EV_THERMAL] && !thermal_warning_irq_mask) |=> irq)
    else $error("thermal flag not reaching interrupt");
  good_pass_a: assert property (@(posedge clk) disable iff (!rstn)
    (event_flags[`QBS_EV_CORE1_GOOD] && !core1_good_irq_mask) |=> irq)
    else $error("power-good flag not reaching interrupt");
  oc_pass_a: assert property (@(posedge clk) disable iff (!rstn)
    (event_flags[`QBS_EV_CORE0_OC] && !core0_overcurrent_irq_mask) |=> irq)
    else $error("current limit flag not reaching interrupt");
endmodule

/* quad_buck_status_irq_mask_tb_top.sv */
// self-checking bench of the status and interrupt mask block
`timescale 1ns/10ps
`include "qbs_consts.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module quad_buck_status_irq_mask_tb_top
  import qbs_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] en = 4'h0;
  logic [3:0] low = 4'h0;
  logic [3:0] oc = 4'h0;
  logic thermal = 1'b0;
  logic rst_pulse = 1'b0;
  logic load_pulse = 1'b0;
  logic [6:0] ev_clr = 7'h00;
  logic [7:0] addr;
  logic wr;
  logic rd;
  qbs_byte_type wdata;
  qbs_byte_type rdata;
  logic [6:0] flags;
  logic irq;
  int error_cnt = 0;
  int compares = 0;
  logic [7:0] got;
  int tm;
  int cm;
  // 100 mhz clock
  always #5 clk = ~clk;
  qbs_status_irq #(.NUM_CORES(4)) i_dut (.clk(clk), .rstn(rstn),
    .core_enabled_flag(en), .core_output_low_raw(low),
    .core_overcurrent_raw(oc), .thermal_warning_raw(thermal),
    .reg_reset_pulse(rst_pulse), .load_ready_pulse(load_pulse),
    .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
    .reg_rdata(rdata), .event_clear(ev_clr), .event_flags(flags), .irq(irq));
  qbs_host_model i_host (.clk(clk), .reg_addr(addr), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata));
  // inputs always change 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // expected status byte of a core pair
  function automatic logic [7:0] stat(input int p);
    return {en[2*p+1], low[2*p+1], 1'b0, oc[2*p+1],
            en[2*p], low[2*p], 1'b0, oc[2*p]};
  endfunction
  // provoke event source i once
  task automatic fire(input int i);
    case (i)
      0: load_pulse = 1'b1;
      1: rst_pulse = 1'b1;
      2: thermal = 1'b1;
      3: oc[0] = 1'b1;
      4: low[0] = 1'b1;
      5: oc[1] = 1'b1;
      default: low[1] = 1'b1;
    endcase
    tick(1);
    load_pulse = 1'b0;
    rst_pulse = 1'b0;
    oc = 4'h0;
    // falling output-low edge means threshold reached
    low = 4'h0;
  endtask
  task automatic final_report();
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #200000;
    error_cnt++;
    $display("unexpected t=%0t watchdog expired", $time);
    final_report();
  end
  initial begin
    void'($urandom(32'h6f1695f9));
    tick(4);
    rstn = 1'b1;
    // reset values, unmapped read
    i_host.rd(8'h1c, got); `CHK(got, 8'h00)
    i_host.rd(8'h1d, got); `CHK(got, 8'h00)
    i_host.rd(8'h1e, got); `CHK(got, 8'h02)
    i_host.rd(8'h1f, got); `CHK(got, 8'h55)
    i_host.rd(8'h20, got); `CHK(got, 8'h00)
    `CHK(flags, 7'h00)
    `CHK(irq, 1'b0)
    $display("test reset done");
    // random raw conditions, status follows; writes there ignored
    for (int k = 0; k < 8; k++) begin
      en = 4'($urandom);
      low = 4'($urandom);
      oc = 4'($urandom);
      i_host.wr(8'h1c, 8'hff);
      i_host.rd(8'h1c, got); `CHK(got, stat(0))
      i_host.rd(8'h1d, got); `CHK(got, stat(1))
    end
    $display("test status done");
    // mask read-back
    for (int k = 0; k < 4; k++) begin
      tm = $urandom % 256;
      cm = $urandom % 256;
      i_host.wr(8'h1e, 8'(tm));
      i_host.wr(8'h1f, 8'(cm));
      i_host.rd(8'h1e, got); `CHK(got, 8'(tm))
      i_host.rd(8'h1f, got); `CHK(got, 8'(cm & 'hdd))
    end
    $display("test masks done");
    // quiet raw inputs, flush flags left by random traffic
    en = 4'h0;
    low = 4'h0;
    oc = 4'h0;
    tick(2);
    ev_clr = 7'h7f;
    tick(1);
    ev_clr = 7'h00;
    i_host.wr(8'h1e, 8'h00);
    i_host.wr(8'h1f, 8'h00);
    tick(2);
    `CHK(flags, 7'h00)
    // each event: flag, irq, mask, unmask, clear
    for (int i = 0; i < 7; i++) begin
      fire(i);
      tick(3);
      `CHK(flags, 7'(1 << i))
      `CHK(irq, 1'b1)
      tick(4);
      `CHK(flags, 7'(1 << i))
      i_host.wr(i < 3 ? 8'h1e : 8'h1f, 8'(1 << (i < 3 ? i : 2 * (i - 3))));
      tick(2);
      `CHK(irq, 1'b0)
      i_host.wr(i < 3 ? 8'h1e : 8'h1f, 8'h00);
      tick(2);
      `CHK(irq, 1'b1)
      thermal = 1'b0;
      ev_clr = 7'(1 << i);
      tick(1);
      ev_clr = 7'h00;
      tick(2);
      `CHK(flags, 7'h00)
      `CHK(irq, 1'b0)
    end
    // clear while limit still active: flag stays
    oc[0] = 1'b1;
    ev_clr = 7'h08;
    tick(1);
    ev_clr = 7'h00;
    oc[0] = 1'b0;
    tick(2);
    `CHK(flags, 7'h08)
    $display("test events done");
    final_report();
  end
endmodule
